// *** design/clk_sel_pkg.sv ***
// Purpose: constants and types for the system clock select and divide block
// Assumes: 8-bit control register reached over a 32-bit Avalon-MM slave
// Notes:   register word offsets are byte addresses of aligned words
package clk_sel_pkg;

   // register map (byte addresses)
   localparam logic [3:0] OSC_CTRL_ADDR    = 4'h0;
   localparam logic [3:0] SEC_TCTRL_ADDR   = 4'h4;
   localparam logic [3:0] CFG_ADDR         = 4'h8;
   localparam logic [3:0] STATUS_ADDR      = 4'hc;

   // oscillator_control fields
   localparam int IDLE_SEL_BIT    = 7;
   localparam int PRI_READY_BIT   = 3;
   localparam int SCS_LSB         = 0;
   localparam logic [7:0] OSC_CTRL_WMASK = 8'h83;

   // secondary_timer_control fields
   localparam int SEC_ACTIVE_BIT  = 6;
   localparam int SEC_EN_BIT      = 3;
   localparam logic [7:0] SEC_TCTRL_WMASK = 8'hbf;

   // configuration word fields
   localparam int CFG_FOSC_LSB    = 0;
   localparam int CFG_CPUDIV_LSB  = 4;
   localparam int CFG_PLLDIV_LSB  = 8;
   localparam int CFG_USB_CLOCK_DIVIDE_CONFIG_BIT  = 11;
   localparam int CFG_TWO_SPEED_STARTUP_CONFIG_BIT    = 12;
   localparam int CFG_LOWSPD_BIT  = 13;
   localparam logic [31:0] CFG_RESET = 32'h0000_0000;

   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

   // switch pause: two old cycles plus four new cycles
   localparam int OLD_PAUSE_CYC = 2;
   localparam int NEW_PAUSE_CYC = 4;

   // start-up timer length in primary oscillator cycles
   localparam int OST_CYCLES    = 1024;

   typedef enum logic [1:0] {
      SRC_PRIMARY   = 2'b00,
      SRC_SECONDARY = 2'b01,
      SRC_INTERNAL  = 2'b10
   } clk_src_t;

   // gray-coded along idle -> pause old -> pause new; pause new -> idle flips both bits
   typedef enum logic [1:0] {
      SW_STABLE   = 2'b00,
      SW_OLD_WAIT = 2'b01,
      SW_NEW_WAIT = 2'b11
   } switch_state_t;

   typedef struct packed {
      logic       primary_en;
      logic       secondary_en;
      logic       internal_rc_en;
      logic       usb_clk_en;
      logic       pll_en;
   } osc_enables_t;

   typedef struct packed {
      logic [3:0] pll_prescale;
      logic [2:0] cpu_postscale;
      logic [2:0] usb_postscale;
      logic       use_pll;
   } div_plan_t;

endpackage : clk_sel_pkg

// *** design/system_clock_select_and_divide.sv ***
// Purpose: device clock source select, prescale/postscale plan, mode control
// Assumes: oscillator ticks arrive as async pins and are synchronised here
// Notes:   analogue oscillators and PLL are outside; this block steers them
// How it works
// - select field: 00 primary, 01 secondary, 1x internal
// - select field cleared on every reset
// - writing select starts switch immediately
// - pause two old plus new cycles
// - watchdog clock always from internal RC
// - primary ready flag follows start-up timer
// - ready flag depends on two-speed setting
// - secondary active flag while secondary clocks
// - at most one source status flag set
// - secondary select ignored when oscillator disabled
// - control bit 7 picks idle or sleep
// - unimplemented control bits read zero
// - primary runs only in run or primary idle
// - USB clock keeps running in run/idle
// - full sleep stops primary, PLL and USB clocks; internal RC keeps running
// - secondary oscillator runs when timer needs it
// - internal modes clock directly from RC
// - postscaler decode differs for PLL modes
// - USB clock 48 MHz, low speed 6 MHz
// - 48 MHz direct USB only when divide clear
// - four-bit field picks primary mode
// - PLL enabled in PLL-based modes
// - secondary run stops primary, flags swap
`timescale 1ns/1ps
`default_nettype none
module system_clock_select_and_divide
   import clk_sel_pkg::*;
#(
   parameter int OST_LEN = OST_CYCLES
) (
   input  wire logic        core_clk_i,
   input  wire logic        sys_rst_i,
   // Avalon-MM slave
   input  wire logic [3:0]  avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   input  wire logic [3:0]  avs_byteenable_i,
   output logic [31:0]      avs_readdata_o,
   output logic             avs_waitrequest_o,
   // core side
   input  wire logic        sleep_cmd_i,
   input  wire logic        secondary_timer_needs_i,
   // oscillator tick inputs from pins
   input  wire logic        primary_tick_i,
   input  wire logic        secondary_tick_i,
   input  wire logic        internal_rc_tick_i,
   // outputs
   output osc_enables_t     osc_enables_o,
   output div_plan_t        div_plan_o,
   output clk_src_t         device_src_o,
   output logic             device_clk_gate_o,
   output logic             cpu_clk_en_o,
   output logic             periph_clk_en_o,
   output logic             watchdog_src_internal_o,
   output logic             idle_mode_o,
   output logic             sleep_mode_o
);

   // ---------------- pin synchronisers and edge detect
   logic [2:0] tick_meta;
   logic [2:0] tick_sync;
   logic [2:0] tick_last;
   logic [2:0] tick_rise;

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         tick_meta <= 3'h0;
         tick_sync <= 3'h0;
         tick_last <= 3'h0;
      end else begin
         tick_meta <= {internal_rc_tick_i, secondary_tick_i, primary_tick_i};
         tick_sync <= tick_meta;
         tick_last <= tick_sync;
      end
   end
   assign tick_rise = tick_sync & ~tick_last;

   function automatic logic src_tick(input clk_src_t s,
                                     input logic [2:0] r);
      case (s)
         SRC_PRIMARY:   src_tick = r[0];
         SRC_SECONDARY: src_tick = r[1];
         default:       src_tick = r[2];
      endcase
   endfunction : src_tick

   // ---------------- registers
   logic       idle_on_sleep_select;
   logic [1:0] system_clock_select;
   logic [7:0] secondary_timer_control;
   logic [31:0] cfg_word;
   logic       wr_osc;
   logic       wr_sec;
   logic       wr_cfg;
   logic       access;

   assign access = avs_read_i | avs_write_i;
   assign wr_osc = avs_write_i && avs_address_i == OSC_CTRL_ADDR
                   && avs_byteenable_i[0];
   assign wr_sec = avs_write_i && avs_address_i == SEC_TCTRL_ADDR
                   && avs_byteenable_i[0];
   assign wr_cfg = avs_write_i && avs_address_i == CFG_ADDR;

   // one-cycle accept: waitrequest stays low, request taken at the edge
   assign avs_waitrequest_o = 1'b0;

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         idle_on_sleep_select <= 1'b0;
         system_clock_select  <= 2'b00;
      end else if (wr_osc) begin
         idle_on_sleep_select <= avs_writedata_i[IDLE_SEL_BIT];
         // secondary request dropped unless oscillator enabled
         if (avs_writedata_i[SCS_LSB +: 2] == SRC_SECONDARY
             && !secondary_timer_control[SEC_EN_BIT])
            system_clock_select <= system_clock_select;
         else
            system_clock_select <= avs_writedata_i[SCS_LSB +: 2];
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i)
         secondary_timer_control <= RESET_BYTE;
      else if (wr_sec)
         secondary_timer_control <= avs_writedata_i[7:0] & SEC_TCTRL_WMASK;
   end

   // configuration bits; byte lanes honoured
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i)
         cfg_word <= CFG_RESET;
      else if (wr_cfg) begin
         for (int b = 0; b < 4; b++) begin
            if (avs_byteenable_i[b])
               cfg_word[b*8 +: 8] <= avs_writedata_i[b*8 +: 8];
         end
      end
   end

   logic [3:0] primary_mode_config;
   logic [1:0] cpu_postscale_select;
   logic [2:0] pll_prescale_select;
   logic       usb_clock_divide_config;
   logic       two_speed_startup_config;
   logic       usb_low_speed;
   assign primary_mode_config      = cfg_word[CFG_FOSC_LSB +: 4];
   assign cpu_postscale_select     = cfg_word[CFG_CPUDIV_LSB +: 2];
   assign pll_prescale_select      = cfg_word[CFG_PLLDIV_LSB +: 3];
   assign usb_clock_divide_config  = cfg_word[CFG_USB_CLOCK_DIVIDE_CONFIG_BIT];
   assign two_speed_startup_config = cfg_word[CFG_TWO_SPEED_STARTUP_CONFIG_BIT];
   assign usb_low_speed            = cfg_word[CFG_LOWSPD_BIT];

   // ---------------- primary mode decode
   // pll modes: low-crystal, crystal, ext clock and ext clock io with pll
   logic use_pll;
   always_comb begin
      case (primary_mode_config)
         4'h2, 4'h6, 4'he, 4'h7: use_pll = 1'b1;
         default:                use_pll = 1'b0;
      endcase
   end

   // ---------------- source switch state machine
   clk_src_t      active_src;
   clk_src_t      target_src;
   switch_state_t sw_state;
   logic [2:0]    sw_count;

   assign target_src = system_clock_select[1] ? SRC_INTERNAL
                     : clk_src_t'(system_clock_select);

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         sw_state   <= SW_STABLE;
         sw_count   <= 3'h0;
         active_src <= SRC_PRIMARY;
      end else begin
         case (sw_state)
            SW_STABLE: begin
               if (target_src != active_src) begin
                  sw_state <= SW_OLD_WAIT;
                  sw_count <= 3'h0;
               end
            end
            SW_OLD_WAIT: begin
               if (src_tick(active_src, tick_rise)) begin
                  if (sw_count == 3'(OLD_PAUSE_CYC - 1)) begin
                     sw_state <= SW_NEW_WAIT;
                     sw_count <= 3'h0;
                  end else
                     sw_count <= sw_count + 3'h1;
               end
            end
            SW_NEW_WAIT: begin
               if (src_tick(target_src, tick_rise)) begin
                  if (sw_count == 3'(NEW_PAUSE_CYC - 1)) begin
                     sw_state   <= SW_STABLE;
                     active_src <= target_src;
                  end else
                     sw_count <= sw_count + 3'h1;
               end
            end
            default: sw_state <= SW_STABLE;
         endcase
      end
   end

   // ---------------- sleep / idle mode
   // no wake input: sleep and idle leave only through reset
   logic in_sleep;
   logic in_idle;
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         in_sleep <= 1'b0;
         in_idle  <= 1'b0;
      end else if (sleep_cmd_i) begin
         in_idle  <= idle_on_sleep_select;
         in_sleep <= !idle_on_sleep_select;
      end
   end

   // ---------------- start-up timer for primary ready flag
   logic [$clog2(OST_LEN+1)-1:0] ost_count;
   logic primary_running;
   logic primary_ready_flag;
   assign primary_running = osc_enables_o.primary_en;

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i)
         ost_count <= '0;
      else if (!primary_running)
         ost_count <= '0;
      else if (tick_rise[0] && ost_count != OST_LEN[$bits(ost_count)-1:0])
         ost_count <= ost_count + 1'b1;
   end

   // with two-speed start the flag waits for the primary to be in use
   always_comb begin
      primary_ready_flag = primary_running
         && ost_count == OST_LEN[$bits(ost_count)-1:0];
      if (two_speed_startup_config)
         primary_ready_flag = primary_ready_flag
            && active_src == SRC_PRIMARY && sw_state == SW_STABLE;
      if (active_src != SRC_PRIMARY)
         primary_ready_flag = 1'b0;
   end

   logic secondary_clock_active_flag;
   assign secondary_clock_active_flag = active_src == SRC_SECONDARY;

   // ---------------- oscillator enables
   always_comb begin
      osc_enables_o.primary_en = !in_sleep
         && (active_src == SRC_PRIMARY || target_src == SRC_PRIMARY);
      if (in_idle && active_src != SRC_PRIMARY)
         osc_enables_o.primary_en = 1'b0;
      osc_enables_o.secondary_en = secondary_timer_control[SEC_EN_BIT]
         && (secondary_timer_needs_i || active_src == SRC_SECONDARY
             || target_src == SRC_SECONDARY);
      osc_enables_o.internal_rc_en = 1'b1;
      osc_enables_o.usb_clk_en = !in_sleep;
      osc_enables_o.pll_en = use_pll && !in_sleep;
      if (in_sleep) begin
         osc_enables_o.primary_en = 1'b0;
         osc_enables_o.secondary_en = secondary_timer_control[SEC_EN_BIT]
            && secondary_timer_needs_i;
      end
   end

   // ---------------- divide plan
   // prescale holds divisor-1 encoded as a code for the PLL input stage
   function automatic logic [3:0] pll_div(input logic [2:0] c);
      case (c)
         3'h0: pll_div = 4'h1;
         3'h1: pll_div = 4'h2;
         3'h2: pll_div = 4'h3;
         3'h3: pll_div = 4'h4;
         3'h4: pll_div = 4'h5;
         3'h5: pll_div = 4'h6;
         3'h6: pll_div = 4'ha;
         default: pll_div = 4'hc;
      endcase
   endfunction : pll_div

   logic [3:0] pll_divisor;
   logic [2:0] cpu_divisor_m1;
   assign pll_divisor = pll_div(pll_prescale_select);

   always_comb begin
      if (use_pll)
         case (cpu_postscale_select)
            2'h0: cpu_divisor_m1 = 3'h1;
            2'h1: cpu_divisor_m1 = 3'h2;
            2'h2: cpu_divisor_m1 = 3'h3;
            default: cpu_divisor_m1 = 3'h5;
         endcase
      else
         cpu_divisor_m1 = {1'b0, cpu_postscale_select};
   end

   // full speed: 96/2 from pll or direct 48 when divide clear and no pll mode;
   // low speed: primary chain /4 gives 6 MHz
   // divide bit set forces the pll path unless low speed; direct 48 MHz needs it clear
   logic [2:0] usb_divisor_m1;
   always_comb begin
      if (usb_low_speed)
         usb_divisor_m1 = 3'h3;
      else if (use_pll || usb_clock_divide_config)
         usb_divisor_m1 = 3'h1;
      else
         usb_divisor_m1 = 3'h0;
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         div_plan_o <= '0;
      end else begin
         // four bits so the /10 and /12 codes keep divisor-1 intact
         div_plan_o.pll_prescale  <= pll_divisor - 4'h1;
         div_plan_o.cpu_postscale <= cpu_divisor_m1;
         div_plan_o.usb_postscale <= usb_divisor_m1;
         div_plan_o.use_pll <= use_pll
            || (usb_clock_divide_config && !usb_low_speed);
      end
   end

   // ---------------- outputs
   assign device_src_o           = active_src;
   assign device_clk_gate_o      = sw_state == SW_STABLE && !in_sleep;
   assign cpu_clk_en_o           = device_clk_gate_o && !in_idle;
   assign periph_clk_en_o        = device_clk_gate_o;
   assign watchdog_src_internal_o = 1'b1;
   assign idle_mode_o            = in_idle;
   assign sleep_mode_o           = in_sleep;

   // ---------------- read mux (same-cycle data, waitrequest low)
   logic [7:0] osc_ctrl_read;
   logic [7:0] sec_read;
   always_comb begin
      osc_ctrl_read = RESET_BYTE;
      osc_ctrl_read[IDLE_SEL_BIT]   = idle_on_sleep_select;
      osc_ctrl_read[PRI_READY_BIT]  = primary_ready_flag;
      osc_ctrl_read[SCS_LSB +: 2]   = system_clock_select;
      sec_read = secondary_timer_control;
      sec_read[SEC_ACTIVE_BIT] = secondary_clock_active_flag;
   end

   always_comb begin
      avs_readdata_o = UNMAPPED_DATA;
      if (avs_read_i && access)
         case (avs_address_i)
            OSC_CTRL_ADDR:  avs_readdata_o = {24'h0, osc_ctrl_read};
            SEC_TCTRL_ADDR: avs_readdata_o = {24'h0, sec_read};
            CFG_ADDR:       avs_readdata_o = cfg_word;
            // status: sleep, idle, switch state, active source
            STATUS_ADDR:    avs_readdata_o = {26'h0, in_sleep, in_idle,
                                              sw_state, active_src};
            default:        avs_readdata_o = UNMAPPED_DATA;
         endcase
   end

endmodule : system_clock_select_and_divide
`default_nettype wire

// *** verif/clk_sel_properties.sv ***
// Purpose: port-level checks for the clock select and divide block
// Assumes: oscillator ticks slower than half the core clock
// Notes:   bound to every instance of the block
`timescale 1ns/1ps
`default_nettype none
module clk_sel_properties
   import clk_sel_pkg::*;
#(
   parameter int OST_LEN = OST_CYCLES
) (
   input wire logic         core_clk_i,
   input wire logic         sys_rst_i,
   input wire logic [3:0]   avs_address_i,
   input wire logic         avs_read_i,
   input wire logic [31:0]  avs_readdata_o,
   input wire logic         avs_waitrequest_o,
   input wire osc_enables_t osc_enables_o,
   input wire clk_src_t     device_src_o,
   input wire logic         device_clk_gate_o,
   input wire logic         cpu_clk_en_o,
   input wire logic         watchdog_src_internal_o,
   input wire logic         idle_mode_o,
   input wire logic         sleep_mode_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (sys_rst_i);

   wait_never_high_a: assert property (!avs_waitrequest_o)
      else $error("waitrequest raised");
   watchdog_on_rc_a: assert property (watchdog_src_internal_o)
      else $error("watchdog not on internal rc");
   reset_primary_a: assert property ($fell(sys_rst_i) |->
      device_src_o == SRC_PRIMARY) else $error("not primary after reset");
   unused_bits_zero_a: assert property (avs_read_i &&
      avs_address_i == OSC_CTRL_ADDR |-> avs_readdata_o[31:8] == 24'h0 &&
      avs_readdata_o[6:4] == 3'h0 && !avs_readdata_o[2])
      else $error("unimplemented control bits not zero");
   src_code_legal_a: assert property (device_src_o != 2'b11)
      else $error("illegal source code");
   pause_min_a: assert property ($fell(device_clk_gate_o) &&
      !sleep_mode_o |-> !device_clk_gate_o [*8])
      else $error("switch pause too short");
   pause_bounded_a: assert property ($fell(device_clk_gate_o) &&
      !sleep_mode_o && !idle_mode_o |-> ##[8:300] device_clk_gate_o)
      else $error("switch pause never ends");
   src_moves_paused_a: assert property ($changed(device_src_o) |->
      !$past(device_clk_gate_o)) else $error("source moved while gated on");
   usb_clock_runs_a: assert property (!sleep_mode_o |->
      osc_enables_o.usb_clk_en) else $error("usb clock stopped");
   sleep_stops_all_a: assert property (sleep_mode_o |->
      !osc_enables_o.primary_en && !osc_enables_o.pll_en &&
      !osc_enables_o.usb_clk_en && !cpu_clk_en_o)
      else $error("clock running in sleep");
   idle_cpu_off_a: assert property (idle_mode_o |->
      !cpu_clk_en_o && !sleep_mode_o) else $error("cpu clocked in idle");
   // look one cycle late: a switch back to primary may start it early
   sec_stops_pri_a: assert property (device_src_o == SRC_SECONDARY &&
      device_clk_gate_o ##1 device_clk_gate_o |->
      !$past(osc_enables_o.primary_en))
      else $error("primary running in secondary mode");
endmodule : clk_sel_properties

bind system_clock_select_and_divide clk_sel_properties #(
   .OST_LEN(OST_LEN)
) u_props (
   .core_clk_i(core_clk_i),
   .sys_rst_i(sys_rst_i),
   .avs_address_i(avs_address_i),
   .avs_read_i(avs_read_i),
   .avs_readdata_o(avs_readdata_o),
   .avs_waitrequest_o(avs_waitrequest_o),
   .osc_enables_o(osc_enables_o),
   .device_src_o(device_src_o),
   .device_clk_gate_o(device_clk_gate_o),
   .cpu_clk_en_o(cpu_clk_en_o),
   .watchdog_src_internal_o(watchdog_src_internal_o),
   .idle_mode_o(idle_mode_o),
   .sleep_mode_o(sleep_mode_o)
);
`default_nettype wire

// *** verif/osc_ticks_model.sv ***
// Purpose: oscillator tick sources seen by the clock select block
// Assumes: each source ticks only while its enable is high
// Notes:   a stopped source holds its level, like a halted crystal
`timescale 1ns/1ps
`default_nettype none
module osc_ticks_model
   import clk_sel_pkg::*;
#(
   parameter int PRI_HALF = 3,
   parameter int SEC_HALF = 5,
   parameter int RC_HALF  = 4
) (
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire osc_enables_t en_i,
   output logic              pri_o,
   output logic              sec_o,
   output logic              rc_o
);
   logic [3:0] pc;
   logic [3:0] sc;
   logic [3:0] rc;

   always_ff @(posedge clk_i) begin
      if (rst_i || pc == 4'(PRI_HALF - 1)) pc <= 4'h0;
      else if (en_i.primary_en) pc <= pc + 4'h1;
      if (rst_i) pri_o <= 1'b0;
      else if (en_i.primary_en && pc == 4'(PRI_HALF - 1)) pri_o <= ~pri_o;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || sc == 4'(SEC_HALF - 1)) sc <= 4'h0;
      else if (en_i.secondary_en) sc <= sc + 4'h1;
      if (rst_i) sec_o <= 1'b0;
      else if (en_i.secondary_en && sc == 4'(SEC_HALF - 1)) sec_o <= ~sec_o;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || rc == 4'(RC_HALF - 1)) rc <= 4'h0;
      else if (en_i.internal_rc_en) rc <= rc + 4'h1;
      if (rst_i) rc_o <= 1'b0;
      else if (en_i.internal_rc_en && rc == 4'(RC_HALF - 1)) rc_o <= ~rc_o;
   end
endmodule : osc_ticks_model
`default_nettype wire

// *** verif/system_clock_select_and_divide_tb.sv ***
// Purpose: self-checking bench for the clock select and divide block
// Assumes: start-up timer shortened to 4 primary ticks
// Notes:   config words random from a fixed seed; first word's mode and divider fields fixed, low speed set only in the second
`timescale 1ns/1ps
`default_nettype none
module system_clock_select_and_divide_tb
   import clk_sel_pkg::*;
;
   logic core_clk_i, sys_rst_i, rd_i, wr_i, sleep_i, needs_i, wait_o, pt, st, it;
   logic gate, cpu_en, per_en, wd, idle, slp;
   logic [3:0] addr, f;
   logic [31:0] wdata, rdata, rd, cfg;
   logic [1:0] cd;
   logic [2:0] pd;
   osc_enables_t en;
   div_plan_t plan;
   clk_src_t src;
   int bad_count, cmp_count, n, i;

   system_clock_select_and_divide #(.OST_LEN(4)) DUT (
      .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
      .avs_address_i(addr), .avs_read_i(rd_i), .avs_write_i(wr_i),
      .avs_writedata_i(wdata), .avs_byteenable_i(4'hf),
      .avs_readdata_o(rdata), .avs_waitrequest_o(wait_o),
      .sleep_cmd_i(sleep_i), .secondary_timer_needs_i(needs_i),
      .primary_tick_i(pt), .secondary_tick_i(st), .internal_rc_tick_i(it),
      .osc_enables_o(en), .div_plan_o(plan), .device_src_o(src),
      .device_clk_gate_o(gate), .cpu_clk_en_o(cpu_en),
      .periph_clk_en_o(per_en), .watchdog_src_internal_o(wd),
      .idle_mode_o(idle), .sleep_mode_o(slp));

   osc_ticks_model u_osc (.clk_i(core_clk_i), .rst_i(sys_rst_i), .en_i(en),
      .pri_o(pt), .sec_o(st), .rc_o(it));

   initial begin
      core_clk_i = 1'b0;
      forever #2 core_clk_i = ~core_clk_i;
   end

   task check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task summarize;
      if (bad_count == 0 && cmp_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : summarize

   task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      int k;
      addr <= a; wdata <= d; wr_i <= w; rd_i <= !w; k = 0;
      do begin @(posedge core_clk_i); k++; end
      while (wait_o !== 1'b0 && k < 100);
      rd = rdata;
      if (k >= 100) begin check(0, 1); summarize; end
      rd_i <= 1'b0; wr_i <= 1'b0;
      @(posedge core_clk_i);
   endtask : bus

   task wait_src(input clk_src_t e);
      int k;
      repeat (3) @(posedge core_clk_i);
      k = 0;
      while (!(src === e && gate === 1'b1) && k < 500) begin
         @(posedge core_clk_i); k++;
      end
      if (k >= 500) begin check(0, 1); summarize; end
   endtask : wait_src

   // start-up timer needs a few primary ticks after the primary restarts
   task wait_ready;
      n = 0;
      do begin bus(0, OSC_CTRL_ADDR, 0); n++; end
      while (rd[PRI_READY_BIT] !== 1'b1 && n < 60);
   endtask : wait_ready

   task pulse_sleep;
      sleep_i <= 1'b1; @(posedge core_clk_i);
      sleep_i <= 1'b0; repeat (2) @(posedge core_clk_i);
   endtask : pulse_sleep

   function automatic logic is_pll(input logic [3:0] m);
      return m inside {4'h2, 4'h6, 4'h7, 4'he};
   endfunction : is_pll

   function automatic logic [2:0] exp_cpu(input logic p, input logic [1:0] c);
      if (p) return (c == 2'h3) ? 3'h5 : 3'({1'b0, c} + 3'h1);
      return {1'b0, c};
   endfunction : exp_cpu

   function automatic logic [3:0] exp_pll(input logic [2:0] c);
      case (c)
         3'h6:    return 4'h9;
         3'h7:    return 4'hb;
         default: return {1'b0, c};
      endcase
   endfunction : exp_pll

   // low speed /4; pll path /2 unless divide clear and no pll mode
   function automatic logic [2:0] exp_usb(input logic p,
                                          input logic [31:0] w);
      if (w[CFG_LOWSPD_BIT]) return 3'h3;
      return (p || w[CFG_USB_CLOCK_DIVIDE_CONFIG_BIT]) ? 3'h1 : 3'h0;
   endfunction : exp_usb

   initial begin
      #400000 check(0, 1);
      summarize;
   end

   initial begin
      sys_rst_i = 1'b1; rd_i = 1'b0; wr_i = 1'b0; sleep_i = 1'b0;
      needs_i = 1'b0; addr = 4'h0; wdata = 32'h0;
      bad_count = 0; cmp_count = 0;
      void'($urandom(32'hf2e860a7));
      repeat (5) @(posedge core_clk_i);
      sys_rst_i <= 1'b0;
      bus(0, OSC_CTRL_ADDR, 0);
      check({24'h0, rd[7:0] & OSC_CTRL_WMASK}, 0);
      wait_ready;
      check(rd[PRI_READY_BIT], 1);
      bus(1, OSC_CTRL_ADDR, 32'h7c);
      bus(0, OSC_CTRL_ADDR, 0);
      check(rd, 32'h08);
      bus(1, 4'h2, 32'hff);
      bus(0, 4'h2, 0);
      check(rd, UNMAPPED_DATA);
      bus(1, OSC_CTRL_ADDR, 1);
      repeat (40) @(posedge core_clk_i);
      bus(0, OSC_CTRL_ADDR, 0);
      check(rd[1:0], 0);
      check(src, SRC_PRIMARY);
      bus(1, OSC_CTRL_ADDR, 2);
      wait_src(SRC_INTERNAL);
      check(src, SRC_INTERNAL);
      bus(0, OSC_CTRL_ADDR, 0);
      check(rd[PRI_READY_BIT], 0);
      // secondary enabled before it is selected; it starts running once selected
      bus(1, SEC_TCTRL_ADDR, 32'h08);
      repeat (20) @(posedge core_clk_i);
      bus(1, OSC_CTRL_ADDR, 1);
      wait_src(SRC_SECONDARY);
      check(src, SRC_SECONDARY);
      bus(0, SEC_TCTRL_ADDR, 0);
      check(rd[7:0], 8'h48);
      bus(0, OSC_CTRL_ADDR, 0);
      check(rd[7:0], 8'h01);
      check(en.primary_en, 0);
      bus(1, OSC_CTRL_ADDR, 3);
      wait_src(SRC_INTERNAL);
      check(src, SRC_INTERNAL);
      bus(0, SEC_TCTRL_ADDR, 0);
      check(rd[SEC_ACTIVE_BIT], 0);
      bus(1, OSC_CTRL_ADDR, 0);
      wait_src(SRC_PRIMARY);
      wait_ready;
      check(rd[PRI_READY_BIT], 1);
      for (i = 0; i < 10; i++) begin
         f = (i == 0) ? 4'he : 4'($urandom % 16);
         cd = (i == 0) ? 2'h3 : 2'($urandom % 4);
         pd = (i == 0) ? 3'h7 : 3'($urandom % 8);
         cfg = {18'h0, 1'(i == 1), 1'($urandom % 2), 1'($urandom % 2),
                pd, 2'h0, cd, f};
         bus(1, CFG_ADDR, cfg);
         bus(0, CFG_ADDR, 0);
         check(rd, cfg);
         check(plan.use_pll, is_pll(f) || (cfg[CFG_USB_CLOCK_DIVIDE_CONFIG_BIT] &&
               !cfg[CFG_LOWSPD_BIT]));
         check(en.pll_en, is_pll(f));
         check(plan.cpu_postscale, exp_cpu(is_pll(f), cd));
         check(plan.pll_prescale, exp_pll(pd));
         check(plan.usb_postscale, exp_usb(is_pll(f), cfg));
         bus(0, OSC_CTRL_ADDR, 0);
         check(rd[PRI_READY_BIT], 1);
      end
      bus(1, CFG_ADDR, 0);
      needs_i <= 1'b1;
      bus(1, OSC_CTRL_ADDR, 32'h80);
      pulse_sleep;
      check(idle, 1);
      check(slp, 0);
      check(cpu_en, 0);
      check(per_en, 1);
      sys_rst_i <= 1'b1;
      repeat (5) @(posedge core_clk_i);
      sys_rst_i <= 1'b0;
      bus(1, SEC_TCTRL_ADDR, 32'h08);
      bus(1, OSC_CTRL_ADDR, 2);
      wait_src(SRC_INTERNAL);
      pulse_sleep;
      check(slp, 1);
      check(per_en, 0);
      check(en.internal_rc_en, 1);
      check(en.primary_en, 0);
      check(en.secondary_en, 1);
      sys_rst_i <= 1'b1;
      repeat (5) @(posedge core_clk_i);
      sys_rst_i <= 1'b0;
      bus(0, OSC_CTRL_ADDR, 0);
      check(rd[1:0], 0);
      check(src, SRC_PRIMARY);
      summarize;
   end
endmodule : system_clock_select_and_divide_tb
`default_nettype wire
